// [rtl/nrf_regs.svh]
// named constants for the reply framer: field values, offsets, lengths
// assumes inclusion by bare name from the package and the design file
`ifndef NRF_REGS_SVH
`define NRF_REGS_SVH

// header field values
`define NRF_LEAP_NONE 2'h0
`define NRF_LEAP_ALARM 2'h3
`define NRF_VERSION 3'h3
`define NRF_MODE_SERVER 3'h4
`define NRF_STRATUM_PRIMARY 8'h01
`define NRF_POLL_DEFAULT 8'h0e
// 1 us resolution: 2^-20 s is the nearest power of two, exponent -20
`define NRF_PRECISION 8'hec
`define NRF_ROOT_ZERO 32'h0000_0000
// ascii "GPS" followed by a zero byte
`define NRF_REFID_GPS 32'h4750_5300

// payload layout, byte offsets within the 48-byte message
`define NRF_MSG_LEN 6'h30
`define NRF_MSG_LAST 6'h2f
`define NRF_OFS_FLAGS 6'h00
`define NRF_OFS_STRATUM 6'h01
`define NRF_OFS_POLL 6'h02
`define NRF_OFS_PRECISION 6'h03
`define NRF_OFS_ROOT_DELAY 6'h04
`define NRF_OFS_ROOT_DISP 6'h08
`define NRF_OFS_REFID 6'h0c
`define NRF_OFS_REF_TS 6'h10
`define NRF_OFS_ORG_TS 6'h18
`define NRF_OFS_RX_TS 6'h20
`define NRF_OFS_TX_TS 6'h28

// client request: transmit timestamp sits at byte 40
`define NRF_REQ_TX_OFS 6'h28
`define NRF_REQ_TX_END 6'h2f

// fifo shape
`define NRF_FIFO_DEPTH 4
`define NRF_BYTE_W 8

`endif

// [rtl/nrf_pkg.sv]
// types shared by the reply framer and its checker, client model and bench
// assumes the constants header sits beside it
`default_nettype none
`include "nrf_regs.svh"

package nrf_pkg;

   // one byte of a udp payload stream
   typedef struct packed {
      logic [7:0] data;
      logic last;
   } nrf_beat_t;

   // utc timebase sample in ntp timestamp format
   typedef struct packed {
      logic [31:0] sec;
      logic [31:0] frac;
   } nrf_ts_t;

   typedef enum logic [1:0] {
      NRF_IDLE = 2'b00,
      NRF_LOAD = 2'b01,
      NRF_SEND = 2'b11,
      NRF_DRAIN = 2'b10
   } nrf_state_t;

endpackage
`default_nettype wire

// [rtl/nrf_reply_framer.sv]
// ntp server reply framer and its output fifo
// assumes a utc timebase on clk_i and a udp stack on both byte streams
//
// What this block does
// - replies leave as udp payload bytes toward the 10/100 ethernet stack
// - header word, root delay, dispersion, ref id, then four 64-bit stamps
// - two-bit leap field: 0 none, 1 minute of 61 s, 2 minute of 59 s
// - leap field reads 3 until the clock was ever synchronised
// - version field is three bits holding 3
// - mode field is three bits holding 4, server
// - version and mode are fixed constants; first byte 0x1c with no warning
// - stratum is eight bits and reports 1, primary gps server
// - poll is signed eight-bit log2 seconds, e.g. 14 for 16384 s
// - precision is signed eight-bit log2 of the one microsecond tick
// - root delay and dispersion are zero in short format
// - reference identifier names gps
// - reference stamp is time of last clock set or correction
// - client stamps its request; reply returns it as originate stamp
// - receive stamp is local time latched when the request arrives
// - transmit stamp is local time captured as the reply leaves
// - every inserted stamp is utc
`timescale 1ns/1ps
`default_nettype none
`include "nrf_regs.svh"

// ----------------------------------------------------------------------
// byte fifo
// ----------------------------------------------------------------------
module nrf_fifo #(
   parameter int WIDTH = 9,
   parameter int DEPTH = `NRF_FIFO_DEPTH
) (
   input wire logic clk_i,
   input wire logic srst_i,
   // fill side
   input wire logic in_valid_i,
   input wire logic [WIDTH-1:0] in_data_i,
   output logic in_ready_o,
   // drain side
   output logic out_valid_o,
   output logic [WIDTH-1:0] out_data_o,
   input wire logic out_ready_i
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [AW-1:0] wr_reg, wr_next, rd_reg, rd_next;
   logic [AW:0] cnt_reg, cnt_next;
   logic push, pop;

   // count runs up to DEPTH so that full and empty never alias
   assign push = in_valid_i && in_ready_o;
   assign pop = out_valid_o && out_ready_i;
   assign in_ready_o = cnt_reg != (AW+1)'(DEPTH);
   assign out_valid_o = cnt_reg != '0;
   assign out_data_o = mem_reg[rd_reg];

   always_comb begin
      wr_next = wr_reg;
      rd_next = rd_reg;
      cnt_next = cnt_reg;
      if (push) begin
         wr_next = (wr_reg == AW'(DEPTH - 1)) ? '0 : wr_reg + AW'(1);
      end
      if (pop) begin
         rd_next = (rd_reg == AW'(DEPTH - 1)) ? '0 : rd_reg + AW'(1);
      end
      if (push && !pop) begin
         cnt_next = cnt_reg + (AW+1)'(1);
      end else if (pop && !push) begin
         cnt_next = cnt_reg - (AW+1)'(1);
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         wr_reg <= '0;
         rd_reg <= '0;
         cnt_reg <= '0;
      end else begin
         wr_reg <= wr_next;
         rd_reg <= rd_next;
         cnt_reg <= cnt_next;
      end
      if (push) begin
         mem_reg[wr_reg] <= in_data_i;
      end
   end
endmodule

// ----------------------------------------------------------------------
// reply framer
// ----------------------------------------------------------------------
module nrf_reply_framer
   import nrf_pkg::*;
#(
   parameter logic [7:0] POLL = `NRF_POLL_DEFAULT
) (
   input wire logic clk_i,
   input wire logic srst_i,
   // utc timebase
   input wire nrf_ts_t utc_now_i,
   input wire logic utc_synced_i,
   input wire logic utc_set_i,
   input wire logic [1:0] leap_pending_i,
   // request payload stream from udp receive
   input wire logic req_valid_i,
   input wire nrf_beat_t req_beat_i,
   output logic req_ready_o,
   // reply payload stream to udp transmit
   output logic rep_valid_o,
   output nrf_beat_t rep_beat_o,
   input wire logic rep_ready_i,
   // status
   output logic busy_o,
   output logic ever_synced_o
);
   // ----------------------------------------------------------------------
   // request capture
   // ----------------------------------------------------------------------
   nrf_state_t state_reg, state_next;
   logic [5:0] rx_idx_reg, rx_idx_next;
   logic [63:0] org_reg, org_next;
   nrf_ts_t rx_ts_reg, rx_ts_next;
   nrf_ts_t ref_ts_reg, ref_ts_next;
   logic synced_reg, synced_next;
   logic [5:0] tx_idx_reg, tx_idx_next;
   logic [63:0] tx_ts_reg, tx_ts_next;
   logic [1:0] leap_reg, leap_next;
   logic req_ready_reg, req_ready_next;
   logic busy_reg, busy_next;
   logic fifo_in_ready;
   logic fifo_push;
   nrf_beat_t beat;
   logic [8:0] fifo_out;
   logic fifo_out_valid;
   logic req_take;
   logic rep_valid_reg, rep_valid_next;
   nrf_beat_t rep_beat_reg, rep_beat_next;
   logic fifo_pop;

   // pick one byte of a 64-bit field, most significant first
   function automatic logic [7:0] byte_of64(input logic [63:0] v, input logic [2:0] i);
      byte_of64 = v[8'(63 - 8 * i) -: 8];
   endfunction

   function automatic logic [7:0] byte_of32(input logic [31:0] v, input logic [1:0] i);
      byte_of32 = v[8'(31 - 8 * i) -: 8];
   endfunction

   assign req_take = req_valid_i && req_ready_reg;

   always_comb begin
      state_next = state_reg;
      rx_idx_next = rx_idx_reg;
      org_next = org_reg;
      rx_ts_next = rx_ts_reg;
      ref_ts_next = ref_ts_reg;
      synced_next = synced_reg;
      tx_idx_next = tx_idx_reg;
      tx_ts_next = tx_ts_reg;
      leap_next = leap_reg;
      req_ready_next = req_ready_reg;
      busy_next = busy_reg;
      // reference stamp follows each set or correction
      if (utc_set_i) begin
         ref_ts_next = utc_now_i;
      end
      if (utc_synced_i) begin
         synced_next = 1'b1;
      end
      case (state_reg)
         NRF_IDLE: begin
            req_ready_next = 1'b1;
            busy_next = 1'b0;
            if (req_take) begin
               // first request byte marks arrival
               rx_ts_next = utc_now_i;
               rx_idx_next = 6'h01;
               busy_next = 1'b1;
               state_next = NRF_LOAD;
               // a one-byte request is short: close the request side like any short one
               if (req_beat_i.last) begin
                  state_next = NRF_IDLE;
                  req_ready_next = 1'b0;
               end
            end
         end
         NRF_LOAD: begin
            if (req_take) begin
               // copy client transmit stamp verbatim
               if (rx_idx_reg >= `NRF_REQ_TX_OFS && rx_idx_reg <= `NRF_REQ_TX_END) begin
                  org_next = {org_reg[55:0], req_beat_i.data};
               end
               rx_idx_next = rx_idx_reg + 6'h01;
               if (req_beat_i.last) begin
                  req_ready_next = 1'b0;
                  // short requests are dropped without a reply
                  if (rx_idx_reg >= `NRF_REQ_TX_END) begin
                     state_next = NRF_SEND;
                     tx_idx_next = '0;
                     // leap code frozen with the request, so one reply carries one value
                     // leap alarm until ever synchronised
                     leap_next = synced_reg ? leap_pending_i : `NRF_LEAP_ALARM;
                  end else begin
                     state_next = NRF_IDLE;
                  end
               end
            end
         end
         NRF_SEND: begin
            if (fifo_in_ready) begin
               // one snapshot as the transmit field starts leaving, so its bytes agree
               if (tx_idx_reg == `NRF_OFS_TX_TS) begin
                  tx_ts_next = utc_now_i;
               end
               tx_idx_next = tx_idx_reg + 6'h01;
               if (tx_idx_reg == `NRF_MSG_LAST) begin
                  state_next = NRF_DRAIN;
               end
            end
         end
         NRF_DRAIN: begin
            // busy spans the reply until the output register has emptied too
            if (!fifo_out_valid && !rep_valid_reg) begin
               state_next = NRF_IDLE;
            end
         end
         default: begin
            state_next = NRF_IDLE;
         end
      endcase
   end

   // ----------------------------------------------------------------------
   // reply byte generation
   // ----------------------------------------------------------------------
   always_comb begin
      beat.last = (tx_idx_reg == `NRF_MSG_LAST);
      if (tx_idx_reg == `NRF_OFS_FLAGS) begin
         // fixed version and mode, never writable
         beat.data = {leap_reg, `NRF_VERSION, `NRF_MODE_SERVER};
      end else if (tx_idx_reg == `NRF_OFS_STRATUM) begin
         beat.data = `NRF_STRATUM_PRIMARY;
      end else if (tx_idx_reg == `NRF_OFS_POLL) begin
         beat.data = POLL;
      end else if (tx_idx_reg == `NRF_OFS_PRECISION) begin
         beat.data = `NRF_PRECISION;
      end else if (tx_idx_reg < `NRF_OFS_REFID) begin
         beat.data = byte_of32(`NRF_ROOT_ZERO, tx_idx_reg[1:0]);
      end else if (tx_idx_reg < `NRF_OFS_REF_TS) begin
         beat.data = byte_of32(`NRF_REFID_GPS, tx_idx_reg[1:0]);
      end else if (tx_idx_reg < `NRF_OFS_ORG_TS) begin
         beat.data = byte_of64(ref_ts_reg, tx_idx_reg[2:0]);
      end else if (tx_idx_reg < `NRF_OFS_RX_TS) begin
         beat.data = byte_of64(org_reg, tx_idx_reg[2:0]);
      end else if (tx_idx_reg < `NRF_OFS_TX_TS) begin
         beat.data = byte_of64(rx_ts_reg, tx_idx_reg[2:0]);
      end else if (tx_idx_reg == `NRF_OFS_TX_TS) begin
         beat.data = utc_now_i.sec[31:24];
      end else begin
         beat.data = byte_of64(tx_ts_reg, tx_idx_reg[2:0]);
      end
   end

   assign fifo_push = (state_reg == NRF_SEND);

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         state_reg <= NRF_IDLE;
         rx_idx_reg <= '0;
         org_reg <= '0;
         rx_ts_reg <= '0;
         ref_ts_reg <= '0;
         synced_reg <= 1'b0;
         tx_idx_reg <= '0;
         tx_ts_reg <= '0;
         leap_reg <= `NRF_LEAP_ALARM;
         req_ready_reg <= 1'b0;
         busy_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         rx_idx_reg <= rx_idx_next;
         org_reg <= org_next;
         rx_ts_reg <= rx_ts_next;
         ref_ts_reg <= ref_ts_next;
         synced_reg <= synced_next;
         tx_idx_reg <= tx_idx_next;
         tx_ts_reg <= tx_ts_next;
         leap_reg <= leap_next;
         req_ready_reg <= req_ready_next;
         busy_reg <= busy_next;
      end
   end

   // ----------------------------------------------------------------------
   // output fifo and registered stream toward udp
   // ----------------------------------------------------------------------
   nrf_fifo #(
      .WIDTH($bits(nrf_beat_t)),
      .DEPTH(`NRF_FIFO_DEPTH)
   ) u_fifo (
      .clk_i(clk_i),
      .srst_i(srst_i),
      .in_valid_i(fifo_push),
      .in_data_i(beat),
      .in_ready_o(fifo_in_ready),
      .out_valid_o(fifo_out_valid),
      .out_data_o(fifo_out),
      .out_ready_i(fifo_pop)
   );

   // refill the output register when it is empty or being taken
   assign fifo_pop = !rep_valid_reg || rep_ready_i;

   always_comb begin
      rep_valid_next = rep_valid_reg;
      rep_beat_next = rep_beat_reg;
      if (fifo_pop) begin
         rep_valid_next = fifo_out_valid;
         rep_beat_next = fifo_out;
      end
   end

   // every reply output leaves straight from a flip-flop
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         rep_valid_reg <= 1'b0;
         rep_beat_reg <= '0;
      end else begin
         rep_valid_reg <= rep_valid_next;
         rep_beat_reg <= rep_beat_next;
      end
   end

   assign req_ready_o = req_ready_reg;
   assign rep_valid_o = rep_valid_reg;
   assign rep_beat_o = rep_beat_reg;
   assign busy_o = busy_reg;
   assign ever_synced_o = synced_reg;
endmodule
`default_nettype wire

// [verification/nrf_chk.sv]
// port assertions for the ntp reply framer
// assumes binding into nrf_reply_framer, one clock, sync reset
`timescale 1ns/1ps
`default_nettype none
module nrf_chk
   import nrf_pkg::*;
(
   // clock and reset
   input wire logic clk_i,
   input wire logic srst_i,
   // inputs
   input wire logic utc_synced_i,
   input wire logic req_valid_i,
   input wire nrf_beat_t req_beat_i,
   input wire logic rep_ready_i,
   // outputs
   input wire logic req_ready_o,
   input wire logic rep_valid_o,
   input wire nrf_beat_t rep_beat_o,
   input wire logic busy_o,
   input wire logic ever_synced_o
);
   // ----------------------------------------------------------------
   // reply byte index and assertions
   // ----------------------------------------------------------------
   logic [5:0] idx_reg;
   logic [5:0] idx_next;
   logic take;
   assign take = rep_valid_o && rep_ready_i;
   always_comb begin
      idx_next = idx_reg;
      if (take) begin
         idx_next = rep_beat_o.last ? 6'h00 : idx_reg + 6'h01;
      end
   end
   always_ff @(posedge clk_i) begin
      idx_reg <= srst_i ? 6'h00 : idx_next;
   end
   default clocking @(posedge clk_i); endclocking
   default disable iff (srst_i);
   sequence stalled_s;
      rep_valid_o && !rep_ready_i;
   endsequence
   sequence held_s;
      rep_valid_o && $stable(rep_beat_o);
   endsequence
   sequence req_end_s;
      req_valid_i && req_ready_o && req_beat_i.last;
   endsequence
   stall_hold_a: assert property (stalled_s |=> held_s)
      else $error("reply beat changed while stalled");
   first_byte_a: assert property (rep_valid_o && idx_reg == 6'h00 |->
      rep_beat_o.data[5:0] == 6'h1c) else $error("version or mode wrong");
   leap_alarm_a: assert property (rep_valid_o && idx_reg == 6'h00 && !ever_synced_o |->
      rep_beat_o.data[7:6] == 2'h3) else $error("leap not alarm while unsynced");
   stratum_one_a: assert property (rep_valid_o && idx_reg == 6'h01 |->
      rep_beat_o.data == 8'h01) else $error("stratum wrong");
   poll_field_a: assert property (rep_valid_o && idx_reg == 6'h02 |->
      rep_beat_o.data == 8'h0e) else $error("poll wrong");
   precision_a: assert property (rep_valid_o && idx_reg == 6'h03 |->
      rep_beat_o.data == 8'hec) else $error("precision wrong");
   root_zero_a: assert property (rep_valid_o && idx_reg inside {[6'h04:6'h0b]} |->
      rep_beat_o.data == 8'h00) else $error("root delay or dispersion nonzero");
   ref_id_a: assert property (rep_valid_o && idx_reg inside {[6'h0c:6'h0f]} |->
      rep_beat_o.data == 8'(32'h4750_5300 >> {6'h0f - idx_reg, 3'h0}))
      else $error("reference id wrong");
   last_flag_a: assert property (rep_valid_o |->
      rep_beat_o.last == (idx_reg == 6'h2f)) else $error("last flag misplaced");
   sync_sticky_a: assert property (utc_synced_i || ever_synced_o |=> ever_synced_o)
      else $error("sync flag lost or late");
   req_close_a: assert property (req_end_s |=> !req_ready_o ##0 busy_o)
      else $error("request side still open");
   no_overlap_a: assert property (rep_valid_o |-> busy_o && !req_ready_o)
      else $error("reply outside busy");
endmodule
bind nrf_reply_framer nrf_chk chk (.clk_i, .srst_i, .utc_synced_i, .req_valid_i, .req_beat_i,
   .rep_ready_i, .req_ready_o, .rep_valid_o, .rep_beat_o, .busy_o, .ever_synced_o);
`default_nettype wire

// [verification/nrf_client.sv]
// ntp client host model: sends request payloads, drains replies
// assumes bench calls its tasks; drives at falling edge
`timescale 1ns/1ps
`default_nettype none
module nrf_client
   import nrf_pkg::*;
(
   // clock
   input wire logic clk_i,
   // request stream
   output logic req_valid_o,
   output nrf_beat_t req_beat_o,
   input wire logic req_ready_i,
   // reply stream
   input wire logic rep_valid_i,
   input wire nrf_beat_t rep_beat_i,
   output logic rep_ready_o
);
   // ----------------------------------------------------------------
   // request and reply tasks
   // ----------------------------------------------------------------
   logic [7:0] got [48];
   int n_got;
   initial begin
      req_valid_o = 1'b0;
      req_beat_o = '0;
      rep_ready_o = 1'b0;
   end
   task automatic send_req(input logic [63:0] org, input int n);
      int w;
      for (int i = 0; i < n; i++) begin
         @(negedge clk_i);
         req_valid_o = 1'b1;
         req_beat_o.data = (i >= 40) ? org[63-8*(i-40) -: 8] : 8'(i);
         req_beat_o.last = (i == n - 1);
         // ready is registered: what stands now is what the next rising edge sees
         w = 0;
         while (req_ready_i !== 1'b1 && w < 200) begin
            @(negedge clk_i);
            w++;
         end
         @(posedge clk_i);
      end
      @(negedge clk_i);
      req_valid_o = 1'b0;
      // released lines show the inverse of the last byte
      req_beat_o = ~req_beat_o;
   endtask
   task automatic get_reply(input bit stall);
      int w;
      n_got = 0;
      w = 0;
      while (n_got < 48 && w < 2000) begin
         @(negedge clk_i);
         rep_ready_o = !stall || w[1];
         // registered reply: the beat standing now is taken at the next rising edge
         if (rep_valid_i === 1'b1 && rep_ready_o) begin
            got[n_got] = rep_beat_i.data;
            n_got++;
         end
         w++;
      end
      @(negedge clk_i);
      rep_ready_o = 1'b0;
   endtask
endmodule
`default_nettype wire

// [verification/tb.sv]
// self-checking bench for the ntp reply framer
// assumes nrf_client as the far side and the checker bound in
`timescale 1ns/1ps
`default_nettype none
module tb;
   import nrf_pkg::*;
   // ----------------------------------------------------------------
   // bench signals, instances, checks
   // ----------------------------------------------------------------
   logic clk_i, srst_i, utc_synced_i, utc_set_i, req_valid_i, req_ready_o;
   logic rep_valid_o, rep_ready_i, busy_o, ever_synced_o;
   logic [1:0] leap_pending_i;
   nrf_ts_t utc_now_i, ref_ts;
   nrf_beat_t req_beat_i, rep_beat_o;
   int errors, n_compared;
   initial begin
      clk_i = 1'b0;
      forever #4 clk_i = ~clk_i;
   end
   nrf_reply_framer uut (.clk_i, .srst_i, .utc_now_i, .utc_synced_i, .utc_set_i,
      .leap_pending_i, .req_valid_i, .req_beat_i, .req_ready_o, .rep_valid_o, .rep_beat_o,
      .rep_ready_i, .busy_o, .ever_synced_o);
   nrf_client cl (.clk_i, .req_valid_o(req_valid_i), .req_beat_o(req_beat_i),
      .req_ready_i(req_ready_o), .rep_valid_i(rep_valid_o), .rep_beat_i(rep_beat_o),
      .rep_ready_o(rep_ready_i));
   task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
      n_compared++;
      if (seen !== exp) begin
         errors++;
         $display("FAIL %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wrap_up();
      $display("compared %0d mismatches %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic set_ref(input logic [31:0] s);
      @(negedge clk_i);
      utc_now_i = {s, 32'h8000_0000};
      utc_set_i = 1'b1;
      ref_ts = utc_now_i;
      @(negedge clk_i);
      utc_set_i = 1'b0;
      utc_now_i = {s + 32'h5, 32'h0};
   endtask
   // rx stamp must be the arrival time, tx stamp the later leaving time
   task automatic full_reply(input logic [7:0] b0, input bit stall);
      nrf_ts_t t1, t2;
      logic [63:0] org;
      logic [383:0] exp;
      logic [7:0] eb;
      string nm;
      t1 = {32'hd000_0100 + 32'(b0), 32'h1234_5678};
      t2 = {t1.sec + 32'h1, 32'h9abc_def0};
      org = {32'hc100_0000 + 32'(b0), 32'h0bad_f00d};
      @(negedge clk_i);
      utc_now_i = t1;
      cl.send_req(org, 48);
      utc_now_i = t2;
      cl.get_reply(stall);
      check("reply length", 64'(cl.n_got), 64'h30);
      exp = {b0, 8'h01, 8'h0e, 8'hec, 64'h0, 32'h4750_5300, ref_ts, org, t1, t2};
      for (int i = 0; i < 48; i++) begin
         eb = exp[383-8*i -: 8];
         nm = $sformatf("byte %0d", i);
         if (i < 16) check(nm, 64'(cl.got[i]), 64'(eb));
         else check(nm, 64'(cl.got[i]), 64'(eb));
      end
      // the request side reopens only once the whole reply has drained
      repeat (2) @(negedge clk_i);
      check("busy after reply", 64'(busy_o), 64'h0);
      check("ready after reply", 64'(req_ready_o), 64'h1);
   endtask
   task automatic short_req();
      logic seen;
      seen = 1'b0;
      cl.send_req(64'h1, 20);
      repeat (40) begin
         @(negedge clk_i);
         seen = seen | rep_valid_o;
      end
      check("short request reply", 64'(seen), 64'h0);
      check("ready after refusal", 64'(req_ready_o), 64'h1);
   endtask
   task automatic sync_pulse();
      @(negedge clk_i);
      utc_synced_i = 1'b1;
      @(negedge clk_i);
      utc_synced_i = 1'b0;
      check("sync flag", 64'(ever_synced_o), 64'h1);
   endtask
   task automatic mid_reset();
      @(negedge clk_i);
      srst_i = 1'b1;
      repeat (2) @(negedge clk_i);
      srst_i = 1'b0;
      check("sync flag after reset", 64'(ever_synced_o), 64'h0);
      check("ready in reset", 64'(req_ready_o), 64'h0);
      check("idle in reset", 64'({busy_o, rep_valid_o}), 64'h0);
   endtask
   // ----------------------------------------------------------------
   // main sequence and watchdog
   // ----------------------------------------------------------------
   initial begin
      errors = 0;
      n_compared = 0;
      srst_i = 1'b1;
      utc_synced_i = 1'b0;
      utc_set_i = 1'b0;
      leap_pending_i = 2'h0;
      utc_now_i = '0;
      ref_ts = '0;
      repeat (2) @(negedge clk_i);
      srst_i = 1'b0;
      set_ref(32'hd000_0000);
      full_reply(8'hdc, 1'b0);
      sync_pulse();
      for (int k = 0; k < 3; k++) begin
         leap_pending_i = 2'(k);
         full_reply({2'(k), 6'h1c}, k[0]);
      end
      set_ref(32'hd100_0000);
      full_reply(8'h9c, 1'b1);
      short_req();
      full_reply(8'h9c, 1'b0);
      mid_reset();
      set_ref(32'hd200_0000);
      full_reply(8'hdc, 1'b1);
      wrap_up();
   end
   initial begin
      repeat (20000) @(posedge clk_i);
      errors++;
      wrap_up();
   end
endmodule
`default_nettype wire
